/* File: src/scpr_top.sv */
// AXI4-Lite register block that reports and clears pending software interrupts
`timescale 1ns/1ps
module scpr_top
    import scpr_pkg::*;
#(
    parameter int          NCPU     = 8,
    parameter bit          SEC_EXT  = 1'b1,
    parameter bit          ARCH_V2  = 1'b1,
    parameter logic [15:0] SGI_IMPL = 16'hFFFF
)(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Write address channel; awuser carries the accessing processor number
    input  wire logic [SCPR_ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic [SCPR_CPU_W-1:0]       s_axi_awuser,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    // Write data channel
    input  wire logic [SCPR_DATA_W-1:0]      s_axi_wdata,
    input  wire logic [SCPR_STRB_W-1:0]      s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // Write response channel
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // Read address channel; aruser carries the accessing processor number
    input  wire logic [SCPR_ADDR_W-1:0]      s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic [SCPR_CPU_W-1:0]       s_axi_aruser,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    // Read data channel
    output logic [SCPR_DATA_W-1:0]           s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Generation of an interrupt from a source towards a set of targets
    input  wire logic                        gen_valid,
    input  wire logic [3:0]                  gen_intid,
    input  wire logic [SCPR_CPU_W-1:0]       gen_src,
    input  wire logic [NCPU-1:0]             gen_targets,
    // Group of each interrupt per target, one means group one
    input  wire logic [NCPU*SCPR_NUM_SGI-1:0] sgi_group1,
    // Pending state per target, 128 bits each, bit = intid*8 + source
    output logic [NCPU*SCPR_PEND_W-1:0]      sgi_pending
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Source fields are eight bits wide, so more processors cannot be encoded
    if (NCPU < 1 || NCPU > SCPR_MAX_CPU) begin : g_bad_ncpu
        $error("scpr_top: NCPU must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address helpers

    // The four words sit at the bank base and the three words above it
    function automatic logic addr_hit(input logic [SCPR_ADDR_W-1:0] addr);
        addr_hit = (addr[SCPR_ADDR_W-1:4] == SCPR_BANK_BASE[SCPR_ADDR_W-1:4]);
    endfunction

    // Register index n selects interrupts 4n to 4n+3
    function automatic logic [1:0] addr_word(input logic [SCPR_ADDR_W-1:0] addr);
        addr_word = addr[3:2];
    endfunction

    // A processor number beyond the build selects no bank at all
    function automatic logic cpu_ok(input logic [SCPR_CPU_W-1:0] cpu);
        cpu_ok = (32'(cpu) < NCPU);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel state

    logic                   awready_ff;
    logic                   aw_held_ff;
    logic [SCPR_ADDR_W-1:0] aw_addr_ff;
    logic                   aw_ns_ff;
    logic [SCPR_CPU_W-1:0]  aw_cpu_ff;
    logic                   wready_ff;
    logic                   w_held_ff;
    logic [SCPR_DATA_W-1:0] w_data_ff;
    logic [SCPR_STRB_W-1:0] w_strb_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;

    logic                   nxt_aw_held;
    logic                   nxt_w_held;
    logic                   nxt_bvalid;

    wire aw_take = s_axi_awvalid && awready_ff;
    wire w_take  = s_axi_wvalid && wready_ff;
    // The write is carried out once both halves are in and no response waits
    wire do_wr   = aw_held_ff && w_held_ff && !bvalid_ff;

    // Each half is held until the write happens; address and data in any order
    assign nxt_aw_held = aw_take ? 1'b1 : (do_wr ? 1'b0 : aw_held_ff);
    assign nxt_w_held  = w_take ? 1'b1 : (do_wr ? 1'b0 : w_held_ff);
    assign nxt_bvalid  = do_wr ? 1'b1 : ((bvalid_ff && s_axi_bready) ? 1'b0 : bvalid_ff);

    // Handshake flops; ready is low in reset and rises at the first edge after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awready_ff <= !nxt_aw_held;
            wready_ff  <= !nxt_w_held;
            bvalid_ff  <= nxt_bvalid;
        end
    end

    // Captured address, attributes and data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_ff <= '0;
            aw_ns_ff   <= 1'b0;
            aw_cpu_ff  <= '0;
            w_data_ff  <= '0;
            w_strb_ff  <= '0;
        end else begin
            if (aw_take) begin
                aw_addr_ff <= s_axi_awaddr;
                aw_ns_ff   <= s_axi_awprot[SCPR_PROT_NS_BIT];
                aw_cpu_ff  <= s_axi_awuser;
            end
            if (w_take) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode

    wire                   wr_hit   = addr_hit(aw_addr_ff);
    wire [1:0]             wr_word  = addr_word(aw_addr_ff);
    wire                   wr_cpuok = cpu_ok(aw_cpu_ff);
    wire [SCPR_CPU_W-1:0]  wr_cpu   = wr_cpuok ? aw_cpu_ff : '0;
    // First version leaves the space reserved: writes are accepted and ignored
    wire                   wr_act   = do_wr && wr_hit && ARCH_V2 && wr_cpuok;
    wire [SCPR_DATA_W-1:0] wr_mask;
    wire [SCPR_DATA_W-1:0] wr_bits  = w_data_ff & wr_mask;
    wire [SCPR_PEND_W-1:0] wr_clr   = SCPR_PEND_W'(wr_bits) << {wr_word, 5'h00};

    scpr_lane_mask #(
        .NCPU     (NCPU),
        .SEC_EXT  (SEC_EXT),
        .SGI_IMPL (SGI_IMPL)
    ) u_wr_mask (
        .word_idx  (wr_word),
        .nonsecure (aw_ns_ff),
        .group1    (sgi_group1[wr_cpu*SCPR_NUM_SGI +: SCPR_NUM_SGI]),
        .strb      (w_strb_ff),
        .mask      (wr_mask)
    );

    // Response: an address outside the four words is refused with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_ff <= SCPR_RESP_OKAY;
        end else if (do_wr) begin
            bresp_ff <= wr_hit ? SCPR_RESP_OKAY : SCPR_RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Generation decode

    wire                   gen_ok  = gen_valid && cpu_ok(gen_src) && SGI_IMPL[gen_intid];
    // Bit intid*8 + source, the same layout the registers use
    wire [SCPR_PEND_W-1:0] gen_bit = SCPR_PEND_W'(1) << {gen_intid, gen_src};

    ////////////////////////////////////////////////////////////////////////////////
    // Per-target pending stores

    scpr_pend_if #(.W(SCPR_PEND_W)) pend_bus [NCPU] ();
    wire [NCPU*SCPR_PEND_W-1:0] pend_flat;

    for (genvar t = 0; t < NCPU; t++) begin : g_target
        // A write only reaches the bank of the processor that made it
        assign pend_bus[t].clr_mask = (wr_act && (32'(aw_cpu_ff) == t)) ? wr_clr : '0;
        assign pend_bus[t].gen_mask = (gen_ok && gen_targets[t]) ? gen_bit : '0;
        assign pend_flat[t*SCPR_PEND_W +: SCPR_PEND_W] = pend_bus[t].pend;

        scpr_pend_store u_store (
            .aclk    (aclk),
            .aresetn (aresetn),
            .bus     (pend_bus[t])
        );
    end

    // Store outputs are flops, passed through without logic
    assign sgi_pending = pend_flat;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel

    logic                   arready_ff;
    logic                   rvalid_ff;
    logic [SCPR_DATA_W-1:0] rdata_ff;
    logic [1:0]             rresp_ff;
    logic                   nxt_rvalid;

    wire                   ar_take  = s_axi_arvalid && arready_ff;
    wire                   rd_hit   = addr_hit(s_axi_araddr);
    wire [1:0]             rd_word  = addr_word(s_axi_araddr);
    wire                   rd_cpuok = cpu_ok(s_axi_aruser);
    wire [SCPR_CPU_W-1:0]  rd_cpu   = rd_cpuok ? s_axi_aruser : '0;
    wire                   rd_ok    = rd_hit && ARCH_V2 && rd_cpuok;
    wire [SCPR_DATA_W-1:0] rd_mask;
    // Reader's own bank, chosen word; masked bits read as zero
    wire [SCPR_DATA_W-1:0] rd_raw   =
        pend_flat[rd_cpu*SCPR_PEND_W + 32'(rd_word)*SCPR_DATA_W +: SCPR_DATA_W];
    wire [SCPR_DATA_W-1:0] rd_word_val = rd_ok ? (rd_raw & rd_mask) : '0;

    // Reads return all four lanes; strobes do not exist on the read side
    scpr_lane_mask #(
        .NCPU     (NCPU),
        .SEC_EXT  (SEC_EXT),
        .SGI_IMPL (SGI_IMPL)
    ) u_rd_mask (
        .word_idx  (rd_word),
        .nonsecure (s_axi_arprot[SCPR_PROT_NS_BIT]),
        .group1    (sgi_group1[rd_cpu*SCPR_NUM_SGI +: SCPR_NUM_SGI]),
        .strb      ({SCPR_STRB_W{1'b1}}),
        .mask      (rd_mask)
    );

    assign nxt_rvalid = ar_take ? 1'b1 : ((rvalid_ff && s_axi_rready) ? 1'b0 : rvalid_ff);

    // One read at a time: a new address is taken only after the data leaves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    // Data is sampled at the taking edge, so it reflects state at that cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_ff <= '0;
            rresp_ff <= SCPR_RESP_OKAY;
        end else if (ar_take) begin
            rdata_ff <= rd_word_val;
            rresp_ff <= rd_hit ? SCPR_RESP_OKAY : SCPR_RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus outputs

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

endmodule

/* File: src/scpr_pkg.sv */
// Constants shared by the software generated interrupt clear-pending register block
// Operation
// - Writing one to a clear bit drops that interrupt's pending state from that source.
// - Writing zero to a clear bit leaves the pending state as it was.
// - A read returns whether the interrupt from that source is pending on the reader.
// - Pending state is held per pair of interrupt number and source processor.
// - Bits of unimplemented interrupts read zero and ignore writes.
// - Byte accesses act only on the addressed byte lanes, word accesses on all four.
// - With security present, group zero bits read zero to non-secure reads and ignore non-secure writes.
// - With fewer than eight processors, bits of absent sources read zero, ignore writes.
// - An access changes only the accessing processor's own pending state.
// - Four registers cover sixteen interrupts by eight sources, four per register.
// - The lowest interrupt of a register sits in bits 7:0, the highest in 31:24.
// - Each connected processor has its own bank, selected by the accessor.
// - The registers exist only in the second version; otherwise the space is reserved.
// - Interrupt x sits in byte x mod 4 of register x div 4.
// - Within a byte field the bit index is the source processor number.
// - An interrupt that is active and pending counts as pending.
package scpr_pkg;

    localparam int          SCPR_ADDR_W      = 12;
    localparam int          SCPR_DATA_W      = 32;
    localparam int          SCPR_STRB_W      = 4;
    localparam int          SCPR_CPU_W       = 3;
    localparam int          SCPR_MAX_CPU     = 8;
    localparam int          SCPR_NUM_SGI     = 16;
    localparam int          SCPR_NUM_REGS    = 4;
    localparam int          SCPR_LANE_W      = 8;
    localparam int          SCPR_PEND_W      = SCPR_NUM_SGI * SCPR_MAX_CPU;
    localparam logic [11:0] SCPR_BANK_BASE   = 12'hF10;
    localparam int          SCPR_PROT_NS_BIT = 1;
    localparam logic [1:0]  SCPR_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SCPR_RESP_SLVERR = 2'h2;

endpackage

/* File: src/scpr_pend_if.sv */
// Carrier between the register logic and one target processor's pending store
`timescale 1ns/1ps
interface scpr_pend_if #(
    parameter int W = 128
);
    logic [W-1:0] clr_mask;
    logic [W-1:0] gen_mask;
    logic [W-1:0] pend;

    modport ctrl  (output clr_mask, output gen_mask, input pend);
    modport store (input clr_mask, input gen_mask, output pend);
endinterface

/* File: src/scpr_pend_store.sv */
// Pending state of all interrupt and source pairs for one target processor
`timescale 1ns/1ps
module scpr_pend_store
    import scpr_pkg::*;
(
    input  wire logic  aclk,
    input  wire logic  aresetn,
    scpr_pend_if.store bus
);

    logic [SCPR_PEND_W-1:0] pending_ff;
    logic [SCPR_PEND_W-1:0] nxt_pending;

    // Set after clear, so a generation in the clearing cycle survives
    assign nxt_pending = (pending_ff & ~bus.clr_mask) | bus.gen_mask;

    // One flop per pair; active and pending stays set here until cleared
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_ff <= '0;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    assign bus.pend = pending_ff;

endmodule

/* File: src/scpr_lane_mask.sv */
// Per-bit access mask for one register word: lanes, sources, groups, implemented
`timescale 1ns/1ps
module scpr_lane_mask
    import scpr_pkg::*;
#(
    parameter int          NCPU     = 8,
    parameter bit          SEC_EXT  = 1'b1,
    parameter logic [15:0] SGI_IMPL = 16'hFFFF
)(
    input  wire logic [1:0]              word_idx,
    input  wire logic                    nonsecure,
    input  wire logic [SCPR_NUM_SGI-1:0] group1,
    input  wire logic [SCPR_STRB_W-1:0]  strb,
    output logic      [SCPR_DATA_W-1:0]  mask
);

    // Byte k of word n is interrupt 4n+k, bit s of it is source s
    for (genvar k = 0; k < SCPR_STRB_W; k++) begin : g_lane
        wire [3:0] intid = {word_idx, 2'(k)};
        wire       lane_ok = strb[k]
                             && SGI_IMPL[intid]
                             && !(SEC_EXT && nonsecure && !group1[intid]);
        for (genvar s = 0; s < SCPR_LANE_W; s++) begin : g_src
            assign mask[k*SCPR_LANE_W + s] = lane_ok && (s < NCPU);
        end
    end

endmodule

/* File: dv/scpr_asserts.sv */
// Port-level checks for the clear-pending register block
`timescale 1ns/1ps
module scpr_asserts
    import scpr_pkg::*;
#(
    parameter int          NCPU     = 8,
    parameter logic [15:0] SGI_IMPL = 16'hFFFF
)(
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic [SCPR_ADDR_W-1:0]      s_axi_awaddr,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [SCPR_ADDR_W-1:0]      s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [SCPR_DATA_W-1:0]      s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic                        gen_valid,
    input wire logic [3:0]                  gen_intid,
    input wire logic [SCPR_CPU_W-1:0]       gen_src,
    input wire logic [NCPU-1:0]             gen_targets,
    input wire logic [NCPU*SCPR_PEND_W-1:0] sgi_pending
);
    // Bank window decode; only 0xF10 to 0xF1F is mapped
    logic in_wr;
    logic in_rd;
    assign in_wr = s_axi_awaddr[11:4] == 8'hF1;
    assign in_rd = s_axi_araddr[11:4] == 8'hF1;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Write path: address and data taken together, answer two edges later
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // No generation, then no write executing: the pending store must not move
    sequence s_quiet;
        !gen_valid ##1 !$rose(s_axi_bvalid);
    endsequence
    property p_b_resp;
        s_wr_take |-> ##2 s_axi_bvalid;
    endproperty
    a_b_resp: assert property (p_b_resp)
        else $error("write answer late");
    property p_wr_err;
        s_wr_take and !in_wr |-> ##2 s_axi_bresp == SCPR_RESP_SLVERR;
    endproperty
    a_wr_err: assert property (p_wr_err)
        else $error("unmapped write not refused");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write answer dropped early");

    ////////////////////////////////////////////////////////////////////////////////
    // Read path
    property p_r_first;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_first: assert property (p_r_first)
        else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data moved while waiting");
    property p_r_err;
        s_axi_arvalid && s_axi_arready && !in_rd |=>
            s_axi_rresp == SCPR_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_r_err: assert property (p_r_err)
        else $error("unmapped read not refused");
    property p_r_ok;
        s_axi_arvalid && s_axi_arready && in_rd |=> s_axi_rresp == SCPR_RESP_OKAY;
    endproperty
    a_r_ok: assert property (p_r_ok)
        else $error("mapped read refused");

    ////////////////////////////////////////////////////////////////////////////////
    // Pending store, generation watched on target zero, quiet check on all targets; a same-edge clear must lose
    property p_gen_set;
        gen_valid && gen_targets[0] && gen_src < NCPU && SGI_IMPL[gen_intid] |=>
            sgi_pending[{$past(gen_intid), $past(gen_src)}];
    endproperty
    a_gen_set: assert property (p_gen_set)
        else $error("generated interrupt not pending");
    property p_quiet;
        s_quiet |-> $stable(sgi_pending);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pending changed with no cause");
endmodule

bind scpr_top scpr_asserts #(.NCPU(NCPU), .SGI_IMPL(SGI_IMPL)) scpr_asserts_i (.*);

/* File: dv/scpr_axi_master.sv */
// Processor-side bus master model that makes the register accesses
`timescale 1ns/1ps
module scpr_axi_master
    import scpr_pkg::*;
(
    input  wire logic                   aclk,
    output logic [SCPR_ADDR_W-1:0]      s_axi_awaddr,
    output logic [2:0]                  s_axi_awprot,
    output logic [SCPR_CPU_W-1:0]       s_axi_awuser,
    output logic                        s_axi_awvalid,
    input  wire logic                   s_axi_awready,
    output logic [SCPR_DATA_W-1:0]      s_axi_wdata,
    output logic [SCPR_STRB_W-1:0]      s_axi_wstrb,
    output logic                        s_axi_wvalid,
    input  wire logic                   s_axi_wready,
    input  wire logic [1:0]             s_axi_bresp,
    input  wire logic                   s_axi_bvalid,
    output logic                        s_axi_bready,
    output logic [SCPR_ADDR_W-1:0]      s_axi_araddr,
    output logic [2:0]                  s_axi_arprot,
    output logic [SCPR_CPU_W-1:0]       s_axi_aruser,
    output logic                        s_axi_arvalid,
    input  wire logic                   s_axi_arready,
    input  wire logic [SCPR_DATA_W-1:0] s_axi_rdata,
    input  wire logic [1:0]             s_axi_rresp,
    input  wire logic                   s_axi_rvalid
    ,output logic                       s_axi_rready
);
    int lag = 0;  // Answer delay in edges; nonzero makes a slow host

    // Idle from time zero
    initial {s_axi_awaddr, s_axi_awprot, s_axi_awuser, s_axi_awvalid, s_axi_wdata,
             s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot,
             s_axi_aruser, s_axi_arvalid, s_axi_rready} = '0;

    // Write; released payload is inverted so a late sample cannot pass by luck
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [2:0] c, input logic ns, output logic [1:0] r);
        int k;
        k = lag;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_awuser, s_axi_awprot} <= {a, c, 1'b0, ns, 1'b0};
        {s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} <= {d, s, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_awready & s_axi_awvalid) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wready & s_axi_wvalid) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            if (k > 0) k--;
            else if (!s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read of one word
    task automatic rd(input logic [11:0] a, input logic [2:0] c, input logic ns,
                      output logic [31:0] d, output logic [1:0] r);
        int k;
        k = lag;
        @(posedge aclk);
        {s_axi_araddr, s_axi_aruser, s_axi_arprot} <= {a, c, 1'b0, ns, 1'b0};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready & s_axi_arvalid) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            if (k > 0) k--;
            else if (!s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
endmodule

/* File: dv/sgi_clear_pending_regs_bench.sv */
// Self-checking bench for the clear-pending register block
`timescale 1ns/1ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module sgi_clear_pending_regs_bench;
    import scpr_pkg::*;
    localparam int NC = 4;  // Four processors leave sources 4 to 7 absent

    logic aclk, aresetn, gen_valid;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [SCPR_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]             s_axi_awprot, s_axi_arprot;
    logic [SCPR_CPU_W-1:0]  s_axi_awuser, s_axi_aruser, gen_src;
    logic [SCPR_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [SCPR_STRB_W-1:0] s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp;
    logic [3:0]             gen_intid;
    logic [NC-1:0]          gen_targets;
    logic [NC*16-1:0]       sgi_group1;
    logic [NC*128-1:0]      sgi_pending;
    int errors = 0;
    int checked = 0;

    // Intid 15 left out so unimplemented bits are seen
    scpr_top #(.NCPU(NC), .SGI_IMPL(16'h7FFF)) scpr_top_i (.*);
    scpr_axi_master scpr_axi_master_i (.*);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One generation pulse
    task automatic gen(input int i, input int s, input logic [NC-1:0] t);
        @(posedge aclk);
        {gen_valid, gen_intid, gen_src, gen_targets} <= {1'b1, 4'(i), 3'(s), t};
        @(posedge aclk);
        gen_valid <= 1'b0;
    endtask

    // Bank word n read by processor c, compared with e
    task automatic rdc(input int n, input int c, input logic ns, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        scpr_axi_master_i.rd(SCPR_BANK_BASE + 12'(4 * n), 3'(c), ns, d, r);
        `CMP(r, SCPR_RESP_OKAY)
        `CMP(d, e)
    endtask

    task automatic wrc(input int n, input int c, input logic ns, input logic [31:0] d,
                       input logic [3:0] s);
        logic [1:0] r;
        scpr_axi_master_i.wr(SCPR_BANK_BASE + 12'(4 * n), d, s, 3'(c), ns, r);
        `CMP(r, SCPR_RESP_OKAY)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt i from source i/4 to target 0, interrupt 0 also to target 1
    task automatic t_map();
        for (int i = 0; i < 16; i++) gen(i, i / 4, (i == 0) ? 4'h3 : 4'h1);
        for (int n = 0; n < 3; n++) rdc(n, 0, 1'b0, 32'h0101_0101 << n);
        rdc(3, 0, 1'b0, 32'h0008_0808);
        rdc(0, 1, 1'b0, 32'h0000_0001);
    endtask

    task automatic t_clear();
        wrc(0, 0, 1'b0, 32'hFFFF_FF00, 4'h1);
        rdc(0, 0, 1'b0, 32'h0101_0101);
        wrc(0, 0, 1'b0, 32'h0000_0100, 4'h2);
        rdc(0, 0, 1'b0, 32'h0101_0001);
        wrc(0, 1, 1'b0, 32'hFFFF_FFFF, 4'hF);
        rdc(0, 1, 1'b0, 32'h0);
        rdc(0, 0, 1'b0, 32'h0101_0001);
        wrc(1, 0, 1'b0, 32'h0000_0001, 4'hF);
        rdc(1, 0, 1'b0, 32'h0202_0202);
        wrc(1, 0, 1'b0, 32'h0000_0002, 4'hF);
        rdc(1, 0, 1'b0, 32'h0202_0200);
    endtask

    // Interrupt 2 made group zero on target 0, then non-secure accesses
    task automatic t_sec();
        @(posedge aclk);
        sgi_group1 <= ~64'h4;
        rdc(0, 0, 1'b1, 32'h0100_0001);
        wrc(0, 0, 1'b1, 32'hFFFF_FFFF, 4'hF);
        rdc(0, 0, 1'b0, 32'h0001_0000);
        sgi_group1 <= '1;
    endtask

    // Sources and processors beyond the built count
    task automatic t_src();
        gen(5, 3, 4'h1);
        gen(5, 6, 4'h1);
        rdc(1, 0, 1'b0, 32'h0202_0A00);
        wrc(1, 5, 1'b0, 32'hFFFF_FFFF, 4'hF);
        wrc(1, 0, 1'b0, 32'h4040_4040, 4'hF);
        rdc(1, 0, 1'b0, 32'h0202_0A00);
        rdc(1, 5, 1'b0, 32'h0);
    endtask

    task automatic t_err();
        logic [31:0] d;
        logic [1:0]  r;
        scpr_axi_master_i.rd(12'hF20, 3'd0, 1'b0, d, r);
        `CMP({r, d}, {SCPR_RESP_SLVERR, 32'h0})
        scpr_axi_master_i.wr(12'hF0C, 32'hFFFF_FFFF, 4'hF, 3'd0, 1'b0, r);
        `CMP(r, SCPR_RESP_SLVERR)
    endtask

    // Clear meets a new generation on the same edge, with a slow host
    task automatic t_race();
        scpr_axi_master_i.lag = 3;
        fork
            wrc(0, 0, 1'b0, 32'h0001_0000, 4'hF);
            begin
                do @(posedge aclk); while (!(s_axi_awvalid && s_axi_awready));
                {gen_valid, gen_intid, gen_src, gen_targets} <= {1'b1, 4'd2, 3'd0, 4'h1};
                @(posedge aclk);
                gen_valid <= 1'b0;
            end
        join
        rdc(0, 0, 1'b0, 32'h0001_0000);
        scpr_axi_master_i.lag = 0;
        wrc(0, 0, 1'b0, 32'h0001_0000, 4'hF);
        rdc(0, 0, 1'b0, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Reset for 20 cycles, then the scenarios in turn
    initial begin
        {aresetn, gen_valid, gen_intid, gen_src, gen_targets} = '0;
        sgi_group1 = '1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_map();
        t_clear();
        t_sec();
        t_src();
        t_err();
        t_race();
        conclude();
    end

    // About 160 cycles are needed; far longer means a hung handshake
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        conclude();
    end
endmodule
